// ===== tb/dms_diag_selector_assertions.sv
// Port checker for the diagnostic mode selector.
`timescale 1ns/1ps
`include "dms_regs.vh"
module dms_diag_selector_assertions
(
    input wire       clk,
    input wire       rst_b,
    input wire       selfTestRun,
    input wire       selfTestDone,
    input wire       selfTestFail,
    input wire       routineRun,
    input wire       routineFail,
    input wire [3:0] routineCode,
    input wire       normalMode,
    input wire       driveSwapEnable,
    input wire [4:0] testCode,
    input wire       driveSelect,
    input wire       halted,
    input wire [3:0] haltCode,
    input wire       runLamp,
    input wire [7:0] lamps,
    input wire [1:0] driveActivity
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire running = routineRun && !halted && testCode != `DMS_CODE_ECHO;
    sequence s_stFail; selfTestRun && selfTestFail; endsequence
    sequence s_rtFail; routineRun && routineFail; endsequence
    a_normal_decode: assert property (normalMode |-> testCode[4:2] == 3'h0)
        else $error("normal mode with diagnostic code");
    a_no_swap: assert property (!normalMode |-> !driveSwapEnable)
        else $error("drive swap in diagnostics");
    a_halt_dark: assert property (halted |-> !runLamp)
        else $error("run lamp lit while halted");
    a_halt_frozen: assert property (halted && $past(halted) |=>
        halted && $stable(haltCode) && $stable(lamps)) else $error("halt not frozen");
    a_routine_halt: assert property (s_rtFail |=>
        halted && haltCode == $past(routineCode) ##1 lamps[3:0] == haltCode)
        else $error("routine halt code wrong");
    a_selftest_lamp: assert property (s_stFail |=> halted ##1 lamps[6])
        else $error("lamp two dark after self-test halt");
    a_selftest_first: assert property (selfTestRun && selfTestDone && !selfTestFail
        |=> routineRun && !selfTestRun) else $error("routine not after self-test");
    a_code_held: assert property (routineRun || halted |=> $stable(testCode))
        else $error("test code moved");
    a_run_lamps: assert property (running && $past(running) |-> lamps[7:6] == 2'h0
        && lamps[0] == $past(driveSelect)) else $error("run lamps wrong");
    a_halt_drive: assert property (halted && $past(halted) && !lamps[6] |->
        driveActivity[driveSelect]) else $error("failing drive lamp dark");
endmodule

// ===== tb/dms_diag_selector_tb.sv
// Self-checking bench for the diagnostic mode selector.
`timescale 1ns/1ps
module dms_diag_selector_tb;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg  [7:0] switchBank = 8'h00;
    reg        selfTestDone = 1'b0;
    reg        selfTestFail = 1'b0;
    reg  [3:0] selfTestCode = 4'h0;
    reg        routineDone = 1'b0;
    reg        routineFail = 1'b0;
    reg  [3:0] routineCode = 4'h0;
    reg        hostIfError = 1'b0;
    wire       writeActive, readActive, normalMode, driveSelect, driveSwapEnable;
    wire       selfTestRun, routineRun, halted, runLamp;
    wire [1:0] densityState, driveActivity;
    wire [4:0] testCode;
    wire [3:0] haltCode;
    wire [7:0] lamps;
    integer    err_count = 0;
    integer    checked = 0;
    integer    k;
    always #12.5 clk = ~clk;
    dms_diag_selector DUT(.clk, .rst_b, .switchBank, .selfTestDone, .selfTestFail,
        .selfTestCode, .routineDone, .routineFail, .routineCode, .hostIfError, .writeActive,
        .readActive, .densityState, .normalMode, .testCode, .driveSelect, .driveSwapEnable,
        .selfTestRun, .routineRun, .halted, .haltCode, .runLamp, .lamps, .driveActivity);
    dms_drive_model drives(.clk, .run(routineRun), .writeActive, .readActive, .densityState);
    task chk(input string what, input [7:0] exp, input [7:0] got);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task power_up(input [7:0] sw);
        rst_b = 1'b0;
        switchBank = sw;
        cyc(16);
        rst_b = 1'b1;
        cyc(6);
    endtask
    task pulse(input st, input done, input fail, input [3:0] code);
        selfTestDone = st && done;
        selfTestFail = st && fail;
        selfTestCode = code;
        routineDone = !st && done;
        routineFail = !st && fail;
        routineCode = code;
        cyc(1);
        {selfTestDone, selfTestFail, routineDone, routineFail} = 4'h0;
        cyc(3);
    endtask
    task t_normal;
        power_up(8'h19);
        chk("normalMode", 8'h01, {7'h0, normalMode});
        chk("driveSwapEnable", 8'h01, {7'h0, driveSwapEnable});
        chk("normal lamps", 8'h80, lamps);
        hostIfError = 1'b1;
        cyc(3);
        hostIfError = 1'b0;
        chk("host error lamps", 8'h8E, lamps);
    endtask
    task t_echo;
        power_up(8'h81);
        chk("testCode", 8'h10, {3'h0, testCode});
        pulse(1'b1, 1'b1, 1'b0, 4'h0);
        switchBank = 8'h86;
        cyc(4);
        chk("echo lamps", 8'h86, lamps);
    endtask
    task t_exer;
        power_up(8'hF1);
        chk("selfTestRun", 8'h01, {7'h0, selfTestRun});
        pulse(1'b1, 1'b1, 1'b0, 4'h0);
        chk("first drive", 8'h01, {7'h0, driveSelect});
        chk("run lamps", 8'h09, lamps & 8'hCD);
        chk("routineRun", 8'h01, {7'h0, routineRun});
        chk("write lamp", 8'h20, lamps & 8'h30);
        pulse(1'b0, 1'b1, 1'b0, 4'h0);
        chk("second drive", 8'h00, {7'h0, driveSelect});
        chk("drive zero lamp", 8'h00, lamps & 8'h01);
        switchBank = 8'h00;
        pulse(1'b0, 1'b1, 1'b0, 4'h0);
        chk("third drive", 8'h01, {7'h0, driveSelect});
        chk("testCode held", 8'h1E, {3'h0, testCode});
        chk("read lamp", 8'h10, lamps & 8'h30);
        pulse(1'b0, 1'b0, 1'b1, 4'hD);
        chk("halt lamps", 8'h0D, {lamps[7:6], 2'h0, lamps[3:0]});
        chk("runLamp", 8'h00, {7'h0, runLamp});
        chk("driveActivity", 8'h02, {6'h0, driveActivity});
        switchBank = 8'hFF;
        cyc(5);
        chk("frozen code", 8'h0D, {4'h0, haltCode});
    endtask
    task t_selffail;
        power_up(8'h61);
        chk("driveSelect", 8'h01, {7'h0, driveSelect});
        chk("self-test lamps", 8'hC0, lamps);
        hostIfError = 1'b1;
        cyc(3);
        chk("halted", 8'h00, {7'h0, halted});
        chk("haltCode idle", 8'h00, {4'h0, haltCode});
        pulse(1'b1, 1'b0, 1'b1, 4'hB);
        hostIfError = 1'b0;
        chk("lamp two", 8'h4B, {1'b0, lamps[6], 2'h0, lamps[3:0]});
    endtask
    task t_codes;
        for (k = 1; k < 16; k = k + 1)
        begin
            power_up(8'h91);
            pulse(1'b1, 1'b1, 1'b0, 4'h0);
            pulse(1'b0, 1'b0, 1'b1, k[3:0]);
            chk("haltCode", {4'h0, k[3:0]}, {4'h0, lamps[3:0]});
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        t_normal;
        t_echo;
        t_exer;
        t_selffail;
        t_codes;
        final_report;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count = err_count + 1;
        final_report;
    end
endmodule
bind dms_diag_selector dms_diag_selector_assertions chk_i(.clk, .rst_b, .selfTestRun,
    .selfTestDone, .selfTestFail, .routineRun, .routineFail, .routineCode, .normalMode,
    .driveSwapEnable, .testCode, .driveSelect, .halted, .haltCode, .runLamp, .lamps,
    .driveActivity);

// ===== tb/dms_drive_model.sv
// Behavioural drive pair that writes, then reads, while a routine runs.
`timescale 1ns/1ps
module dms_drive_model
(
    input  wire       clk,
    input  wire       run,
    output wire       writeActive,
    output wire       readActive,
    output wire [1:0] densityState
);
    reg [3:0] phase = 4'h0;
    always @(posedge clk)
        phase <= run ? phase + 4'h1 : 4'h0;
    // An idle drive has no head loaded, so its density reads none.
    assign densityState = run ? 2'h2 : 2'h0;
    assign writeActive  = run && !phase[3];
    assign readActive   = run && phase[3];
endmodule

// ===== verilog/dms_diag_selector.v
// Diagnostic mode selector, sequencing and indicator lamp driver.
`timescale 1ns/1ps
`include "dms_regs.vh"
module dms_diag_selector
(
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] switchBank,
    input  wire       selfTestDone,
    input  wire       selfTestFail,
    input  wire [3:0] selfTestCode,
    input  wire       routineDone,
    input  wire       routineFail,
    input  wire [3:0] routineCode,
    input  wire       hostIfError,
    input  wire       writeActive,
    input  wire       readActive,
    input  wire [1:0] densityState,
    output reg        normalMode,
    output reg  [4:0] testCode,
    output reg        driveSelect,
    output reg        driveSwapEnable,
    output reg        selfTestRun,
    output reg        routineRun,
    output reg        halted,
    output reg  [3:0] haltCode,
    output reg        runLamp,
    output reg  [7:0] lamps,
    output reg  [1:0] driveActivity
);
    // Power-up order is sample, then normal operation, or sample, self-test, routine, with a halt after a self-test or routine failure.
    localparam ST_SAMPLE = 3'd0;
    localparam ST_SELF   = 3'd1;
    localparam ST_ROUT   = 3'd2;
    localparam ST_HALT   = 3'd3;
    localparam ST_NORMAL = 3'd4;

    // Switch bank is asynchronous to clk, so each bit is double registered.
    wire [7:0] swSync;
    reg  [2:0] state;
    reg        twoDrives;
    reg        selfFailed;
    reg        swSettled;
    reg  [7:0] next_lamps;
    reg  [1:0] next_driveActivity;
    reg  [1:0] settleCount;

    // Exerciser codes treat switch eight as a drive count.
    function isExerciser;
        input [4:0] code;
        begin
            isExerciser = (code == `DMS_CODE_EXER_FMT) || (code == `DMS_CODE_EXER);
        end
    endfunction

    // One-hot activity lamp pattern for the selected drive.
    function [1:0] driveMask;
        input sel;
        input on;
        begin
            driveMask = {sel & on, ~sel & on};
        end
    endfunction

    // Each switch passes two flip-flops before any logic reads it.
    genvar swIdx;
    generate
        for (swIdx = 0; swIdx < 8; swIdx = swIdx + 1)
        begin : gSwSync
            reg swMeta;
            reg swStage;

            always @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    swMeta <= 1'b0;
                    swStage <= 1'b0;
                end
                else
                begin
                    swMeta <= switchBank[swIdx];
                    swStage <= swMeta;
                end
            end

            assign swSync[swIdx] = swStage;
        end
    endgenerate

    // The bank is read only after both stages hold a real switch value.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settleCount <= 2'h0;
        end
        else if (settleCount != `DMS_SYNC_SETTLE)
        begin
            settleCount <= settleCount + 2'h1;
        end
    end

    always @*
    begin
        swSettled = (settleCount == `DMS_SYNC_SETTLE);
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_SAMPLE;
            normalMode <= 1'b0;
            testCode <= 5'h00;
            driveSelect <= 1'b0;
            twoDrives <= 1'b0;
            driveSwapEnable <= 1'b0;
            selfTestRun <= 1'b0;
            routineRun <= 1'b0;
            halted <= 1'b0;
            haltCode <= `DMS_ERR_NONE;
            selfFailed <= 1'b0;
            runLamp <= 1'b0;
        end
        else
        begin
            case (state)
                ST_SAMPLE:
                begin
                    // Selection is taken once after power-up only.
                    if (swSettled)
                    begin
                        testCode <= swSync[7:3];
                        runLamp <= 1'b1;
                        if (swSync[7:5] == 3'b000)
                        begin
                            normalMode <= 1'b1;
                            driveSwapEnable <= swSync[3];
                            state <= ST_NORMAL;
                        end
                        else
                        begin
                            driveSwapEnable <= 1'b0;
                            twoDrives <= isExerciser(swSync[7:3]) & swSync[0];
                            // Two-drive exerciser starts on drive one.
                            driveSelect <= swSync[0];
                            selfTestRun <= 1'b1;
                            state <= ST_SELF;
                        end
                    end
                end
                ST_SELF:
                begin
                    if (selfTestFail)
                    begin
                        selfTestRun <= 1'b0;
                        selfFailed <= 1'b1;
                        haltCode <= selfTestCode;
                        halted <= 1'b1;
                        runLamp <= 1'b0;
                        state <= ST_HALT;
                    end
                    else if (selfTestDone)
                    begin
                        selfTestRun <= 1'b0;
                        routineRun <= 1'b1;
                        state <= ST_ROUT;
                    end
                end
                ST_ROUT:
                begin
                    // A failure wins over a done pulse in the same cycle.
                    if (routineFail)
                    begin
                        routineRun <= 1'b0;
                        haltCode <= routineCode;
                        halted <= 1'b1;
                        runLamp <= 1'b0;
                        state <= ST_HALT;
                    end
                    else if (routineDone && twoDrives)
                    begin
                        driveSelect <= ~driveSelect;
                    end
                end
                ST_HALT:
                begin
                    // Only a power cycle leaves the halt, so switch changes are ignored.
                    state <= ST_HALT;
                end
                ST_NORMAL:
                begin
                    // Host errors belong to normal operation only.
                    if (hostIfError)
                    begin
                        haltCode <= `DMS_ERR_HOSTPAR;
                    end
                end
                default:
                begin
                    state <= ST_SAMPLE;
                end
            endcase
        end
    end

    // Lamps are a registered copy of the pattern that the current state asks for.
    always @*
    begin
        next_lamps = `DMS_RST_LAMPS;
        case (state)
            ST_SELF:
            begin
                next_lamps[7] = 1'b1;
                next_lamps[6] = 1'b1;
            end
            ST_ROUT:
            begin
                if (testCode == `DMS_CODE_ECHO)
                begin
                    next_lamps = swSync;
                end
                else
                begin
                    next_lamps[7:6] = 2'b00;
                    next_lamps[5] = writeActive;
                    next_lamps[4] = readActive;
                    next_lamps[3] = densityState == `DMS_DENS_DOUBLE;
                    next_lamps[2] = densityState == `DMS_DENS_SINGLE;
                    next_lamps[0] = driveSelect;
                end
            end
            ST_HALT:
            begin
                next_lamps[6] = selfFailed;
                next_lamps[3:0] = haltCode;
            end
            ST_NORMAL:
            begin
                next_lamps[7] = 1'b1;
                next_lamps[5] = writeActive;
                next_lamps[4] = readActive;
                next_lamps[3:0] = haltCode;
            end
            default:
            begin
                next_lamps = `DMS_RST_LAMPS;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lamps <= `DMS_RST_LAMPS;
        end
        else
        begin
            lamps <= next_lamps;
        end
    end

    // Only the selected drive shows activity; a routine failure leaves it lit.
    always @*
    begin
        next_driveActivity = `DMS_RST_DRIVES;
        case (state)
            ST_ROUT:
            begin
                if (routineFail)
                begin
                    next_driveActivity = driveMask(driveSelect, 1'b1);
                end
                else
                begin
                    next_driveActivity = driveMask(driveSelect, writeActive | readActive);
                end
            end
            ST_HALT:
            begin
                next_driveActivity = driveActivity;
            end
            default:
            begin
                next_driveActivity = `DMS_RST_DRIVES;
            end
        endcase
    end

    // Activity lamps are registered like the indicator lamps.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            driveActivity <= `DMS_RST_DRIVES;
        end
        else
        begin
            driveActivity <= next_driveActivity;
        end
    end
endmodule

// ===== verilog/dms_regs.vh
// Constants for the diagnostic mode selector and status lamp block.
`ifndef DMS_REGS_VH
`define DMS_REGS_VH
`define DMS_CODE_ECHO      5'h10
`define DMS_CODE_EXER_FMT  5'h1E
`define DMS_CODE_EXER      5'h1F
`define DMS_ERR_NONE       4'h0
`define DMS_ERR_OPERATOR   4'h1
`define DMS_ERR_IFCABLE    4'h3
`define DMS_ERR_DRVCABLE   4'h4
`define DMS_ERR_DENSITY    4'h5
`define DMS_ERR_SEEK       4'h6
`define DMS_ERR_DATACRC    4'h8
`define DMS_ERR_SECTOR     4'h9
`define DMS_ERR_READSIG    4'hA
`define DMS_ERR_RWCTRL     4'hB
`define DMS_ERR_MASTER     4'hC
`define DMS_ERR_DRIVE      4'hD
`define DMS_ERR_PATTERN    4'hE
`define DMS_ERR_WRITE      4'hF
`define DMS_DENS_NONE      2'h0
`define DMS_DENS_SINGLE    2'h1
`define DMS_DENS_DOUBLE    2'h2
`define DMS_RST_LAMPS      8'h00
`define DMS_RST_DRIVES     2'h0
`define DMS_ERR_HOSTPAR    4'hE
`define DMS_SYNC_SETTLE    2'h2
`endif
